// [rtl/rta_pkg.sv]
// Constants, field layouts and carrier types for the real-time clock block.
// Assumes a single 100 MHz system clock; every slower rate is an enable.
package rta_pkg;
  localparam int unsigned SYS_HZ      = 100_000_000;
  localparam int unsigned SUB_HZ      = 128;
  localparam int unsigned TICK_DIV_DF = SYS_HZ / SUB_HZ;
  localparam int unsigned DIV_W       = 20;
  // Calendar field limits
  localparam logic [6:0] SUB_LO = 7'h00;
  localparam logic [6:0] SUB_HI = 7'h7f;
  localparam logic [5:0] SEC_LO = 6'h00;
  localparam logic [5:0] SEC_HI = 6'h3b;
  localparam logic [4:0] HR_LO  = 5'h00;
  localparam logic [4:0] HR_HI  = 5'h17;
  localparam logic [4:0] HR_12  = 5'h0c;
  localparam logic [2:0] DAY_LO = 3'h1;
  localparam logic [2:0] DAY_HI = 3'h7;
  localparam logic [4:0] DATE_LO = 5'h01;
  localparam logic [4:0] DAYS_28 = 5'h1c;
  localparam logic [4:0] DAYS_29 = 5'h1d;
  localparam logic [4:0] DAYS_30 = 5'h1e;
  localparam logic [4:0] DAYS_31 = 5'h1f;
  localparam logic [3:0] MON_LO  = 4'h1;
  localparam logic [3:0] MON_HI  = 4'hc;
  localparam logic [3:0] MON_FEB = 4'h2;
  localparam logic [3:0] MON_APR = 4'h4;
  localparam logic [3:0] MON_JUN = 4'h6;
  localparam logic [3:0] MON_SEP = 4'h9;
  localparam logic [3:0] MON_NOV = 4'hb;
  localparam logic [6:0] YR_LO   = 7'h00;
  localparam logic [6:0] YR_HI   = 7'h63;
  // Square wave select and timer tick select
  localparam logic [2:0] SQ_SEL_MAX = 3'h6;
  localparam logic [1:0] TMR_128HZ  = 2'h0;
  localparam logic [1:0] TMR_16HZ   = 2'h1;
  localparam logic [1:0] TMR_1HZ    = 2'h2;
  localparam logic [2:0] SUB_16_MSK = 3'h7;
  // Supply selection codes
  localparam logic [1:0] SUP_AUTO   = 2'h0;
  localparam logic [1:0] SUP_MAIN   = 2'h1;
  localparam logic [1:0] SUP_BACKUP = 2'h2;
  // Alarm ignore-mask bit positions
  localparam int ALM_X_SEC  = 0;
  localparam int ALM_X_MIN  = 1;
  localparam int ALM_X_HR   = 2;
  localparam int ALM_X_DATE = 3;
  // Timestamp storage
  localparam int unsigned TS_RECS  = 4;
  localparam int unsigned TS_BYTES = 8;
  localparam int unsigned RAM_SIZE = TS_RECS * TS_BYTES;
  localparam logic [2:0]  TS_FULL  = 3'h4;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] date;
    logic [2:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rta_time_t;

  typedef struct packed {
    logic [3:0] ignore;
    logic [4:0] date;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rta_alarm_t;

  typedef struct packed {
    logic on_backup;
    logic din;
    logic tmr;
    logic a2;
    logic a1;
  } rta_flags_t;

  typedef enum logic [1:0] {
    PS_ON  = 2'b01,
    PS_OFF = 2'b10
  } rta_psw_t;
endpackage

// [rtl/rta_wrap.sv]
// Wrapping calendar field counter with load and carry.
// Assumes inc and ld come from logic on the same clock.
`timescale 1ns/10ps
module rta_wrap #(
  parameter int         W  = 6,
  parameter logic [W-1:0] LO = '0
) (
  input  wire logic         clk,    // System clock
  input  wire logic         rstn,   // Synchronous reset, low
  input  wire logic         inc,    // Count enable
  input  wire logic         ld,     // Load strobe
  input  wire logic [W-1:0] hi,     // Last value before wrap
  input  wire logic [W-1:0] ld_val, // Value to load
  output logic      [W-1:0] val,    // Current value
  output logic              wrap    // Carry to next field
);
  // Carry out when counting past the last value
  assign wrap = inc && (val >= hi);

  // Counter state, load has priority over counting
  always_ff @(posedge clk) begin
    if (!rstn) begin
      val <= LO;
    end else if (ld) begin
      val <= ld_val;
    end else if (wrap) begin
      val <= LO;
    end else if (inc) begin
      val <= val + 1'b1;
    end
  end
endmodule

// [rtl/rta_top.sv]
// Real-time clock core: calendar, alarms, timer, power switch, supply
// select, trickle charge, event timestamps and RAM. Host access is by
// plain ports on the system clock; pins pass a three-stage synchroniser.
`timescale 1ns/10ps
module rta_top #(
  parameter int unsigned TICK_DIV = rta_pkg::TICK_DIV_DF
) (
  input  wire logic               CLK_SYS,     // 100 MHz clock
  input  wire logic               RESETN,      // Sync reset, low
  input  wire logic               SET_STB,     // Load time pulse
  input  wire rta_pkg::rta_time_t SET_TIME,    // Time to load, 24h
  input  wire logic               FMT_12H,     // 12-hour display
  output rta_pkg::rta_time_t      TIME_O,      // Current time
  output logic                    PM_O,        // Afternoon in 12h
  output logic [6:0]              SUBSEC_O,    // 1/128 s count
  input  wire logic               SQUARE_WAVE_OUTPUT_EN,   // Square wave on
  input  wire logic [2:0]         SQUARE_WAVE_OUTPUT_SEL,  // 2^sel Hz, capped at 64 Hz
  input  wire rta_pkg::rta_alarm_t ALM1_CFG,   // First alarm
  input  wire logic               ALM1_IE,     // First alarm irq en
  input  wire rta_pkg::rta_alarm_t ALM2_CFG,   // Second alarm
  input  wire logic               ALM2_IE,     // Second alarm irq en
  input  wire logic               TMR_EN,      // Timer run
  input  wire logic               TMR_IE,      // Timer irq enable
  input  wire logic [1:0]         TMR_SEL,     // Timer tick rate
  input  wire logic [7:0]         TMR_INIT,    // Timer start value
  output logic [7:0]              TMR_CNT_O,   // Timer count
  input  wire logic               FLAG_RD,     // Flag read pulse
  output rta_pkg::rta_flags_t     FLAGS_O,     // Flags as read
  input  wire logic               DIN_PIN,     // Event input pin
  input  wire logic               DIN_RISE,    // 1 rising, 0 falling
  input  wire logic               DIN_IE,      // Event irq enable
  input  wire logic               SLEEP_REQUEST_BIT, // Sleep request
  input  wire logic               WAKE_TMR_EN, // Timer wakes switch
  output logic                    PSW_ON_O,    // Power switch closed
  input  wire logic [1:0]         SUPPLY_SEL,  // Auto, main, backup
  input  wire logic [2:0]         POWER_FAIL_THRESHOLD, // Trip level
  output logic [2:0]              PFAIL_THR_O, // Level to comparator
  input  wire logic               VCC_LOW_PIN, // Main below level
  output logic                    ON_BACKUP_O, // Running on backup
  input  wire logic               TRK_EN,      // Trickle enable
  input  wire logic [1:0]         TRK_RATE,    // Charge rate select
  output logic                    TRK_ON_O,    // Charge path on
  output logic [1:0]              TRK_RATE_O,  // Charge rate
  input  wire logic               TS_EN,       // Timestamp mode
  input  wire logic [2:0]         TS_EV_EN,    // Event enables
  input  wire logic               TS_OVW,      // Keep latest four
  input  wire logic               TS_RST,      // Clear records
  output logic [2:0]              TS_CNT_O,    // Records held
  input  wire logic               MEM_WE,      // RAM write
  input  wire logic [4:0]         MEM_ADDR,    // Byte address
  input  wire logic [7:0]         MEM_WDATA,   // Write data
  output logic [7:0]              MEM_RDATA_O, // Read data
  output logic                    IRQ_LINE_PRIMARY_O,  // A pin level
  output logic                    IRQ_LINE_PRIMARY_OE, // A pin drive
  output logic                    IRQ_OR_CLOCK_OUTPUT_PIN_O,  // B level
  output logic                    IRQ_OR_CLOCK_OUTPUT_PIN_OE  // B drive
);
  import rta_pkg::*;

  logic [DIV_W-1:0] div_reg;
  logic             tick;
  logic [6:0]       sub_v;
  logic [5:0]       sec_v, min_v;
  logic [4:0]       hr_v, date_v, dim;
  logic [2:0]       day_v;
  logic [3:0]       mon_v;
  logic [6:0]       yr_v;
  logic sub_wrap, sec_wrap, min_wrap, hr_wrap, date_wrap, mon_wrap;
  logic             sec_tick_d;
  logic [1:0]       sy1, sy2, sy3, st_reg;
  logic             din_ev, to_bat_ev, to_main_ev;
  logic             on_bak_reg, on_bak_next;
  logic             a1_set, a2_set, tmr_zero;
  rta_flags_t       flags_reg, set_v;
  logic             irqa_reg, irqb_reg, sq_reg;
  logic             tmr_en_d, tmr_tick;
  logic [7:0]       tmr_cnt;
  logic             slp_d, slp_rise;
  rta_psw_t         ps_reg, ps_next;
  logic [7:0]       mem [0:RAM_SIZE-1];
  logic [2:0]       ts_cnt;
  logic [2:0]       ts_ev;
  logic             ts_go;
  logic [63:0]      rec;
  logic [2:0]       sq_sel;
  logic             a1_irq, a2_irq, tm_irq, dn_irq;

  // Days in the current month, year counted from 2000
  function automatic logic [4:0] dim_f(input logic [3:0] m,
                                       input logic [6:0] y);
    if (m == MON_FEB) begin
      return (y[1:0] == 2'h0) ? DAYS_29 : DAYS_28;
    end else if (m == MON_APR || m == MON_JUN || m == MON_SEP ||
                 m == MON_NOV) begin
      return DAYS_30;
    end else begin
      return DAYS_31;
    end
  endfunction

  // Alarm compare with per-field ignore mask
  function automatic logic alm_hit(input rta_alarm_t a,
                                   input logic [5:0] s, input logic [5:0] m,
                                   input logic [4:0] h, input logic [4:0] d);
    return (a.ignore[ALM_X_SEC]  || a.sec  == s) &&
           (a.ignore[ALM_X_MIN]  || a.min  == m) &&
           (a.ignore[ALM_X_HR]   || a.hour == h) &&
           (a.ignore[ALM_X_DATE] || a.date == d);
  endfunction

  // 128 Hz enable from the system clock, restarted by a time write
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN || SET_STB) begin
      div_reg <= '0;
    end else if (tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign tick = (div_reg == DIV_W'(TICK_DIV - 1));

  // Calendar chain, each field except day of week carries into the next
  assign dim = dim_f(mon_v, yr_v);
  rta_wrap #(.W(7), .LO(SUB_LO)) u_sub (.clk(CLK_SYS), .rstn(RESETN),
    .inc(tick), .ld(SET_STB), .hi(SUB_HI), .ld_val(SUB_LO),
    .val(sub_v), .wrap(sub_wrap));
  rta_wrap #(.W(6), .LO(SEC_LO)) u_sec (.clk(CLK_SYS), .rstn(RESETN),
    .inc(sub_wrap), .ld(SET_STB), .hi(SEC_HI), .ld_val(SET_TIME.sec),
    .val(sec_v), .wrap(sec_wrap));
  rta_wrap #(.W(6), .LO(SEC_LO)) u_min (.clk(CLK_SYS), .rstn(RESETN),
    .inc(sec_wrap), .ld(SET_STB), .hi(SEC_HI), .ld_val(SET_TIME.min),
    .val(min_v), .wrap(min_wrap));
  rta_wrap #(.W(5), .LO(HR_LO)) u_hr (.clk(CLK_SYS), .rstn(RESETN),
    .inc(min_wrap), .ld(SET_STB), .hi(HR_HI), .ld_val(SET_TIME.hour),
    .val(hr_v), .wrap(hr_wrap));
  rta_wrap #(.W(3), .LO(DAY_LO)) u_day (.clk(CLK_SYS), .rstn(RESETN),
    .inc(hr_wrap), .ld(SET_STB), .hi(DAY_HI), .ld_val(SET_TIME.day),
    .val(day_v), .wrap());
  rta_wrap #(.W(5), .LO(DATE_LO)) u_date (.clk(CLK_SYS), .rstn(RESETN),
    .inc(hr_wrap), .ld(SET_STB), .hi(dim), .ld_val(SET_TIME.date),
    .val(date_v), .wrap(date_wrap));
  rta_wrap #(.W(4), .LO(MON_LO)) u_mon (.clk(CLK_SYS), .rstn(RESETN),
    .inc(date_wrap), .ld(SET_STB), .hi(MON_HI), .ld_val(SET_TIME.month),
    .val(mon_v), .wrap(mon_wrap));
  rta_wrap #(.W(7), .LO(YR_LO)) u_yr (.clk(CLK_SYS), .rstn(RESETN),
    .inc(mon_wrap), .ld(SET_STB), .hi(YR_HI), .ld_val(SET_TIME.year),
    .val(yr_v), .wrap());

  // Registered time view with optional 12-hour hours
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      TIME_O   <= '0;
      PM_O     <= 1'b0;
      SUBSEC_O <= '0;
    end else begin
      TIME_O   <= '{yr_v, mon_v, date_v, day_v, hr_v, min_v, sec_v};
      SUBSEC_O <= sub_v;
      PM_O     <= FMT_12H && (hr_v >= HR_12);
      if (FMT_12H && hr_v == HR_LO) begin
        TIME_O.hour <= HR_12;
      end else if (FMT_12H && hr_v > HR_12) begin
        TIME_O.hour <= hr_v - HR_12;
      end
    end
  end

  // Three-stage synchroniser for event input and supply comparator
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      sy1    <= '0;
      sy2    <= '0;
      sy3    <= '0;
      st_reg <= '0;
    end else begin
      sy1 <= {VCC_LOW_PIN, DIN_PIN};
      sy2 <= sy1;
      sy3 <= sy2;
      for (int i = 0; i < 2; i++) begin
        if (sy2[i] == sy3[i]) begin
          st_reg[i] <= sy3[i];
        end
      end
    end
  end
  assign din_ev = (sy2[0] == sy3[0]) && (sy3[0] != st_reg[0]) &&
                  (sy3[0] == DIN_RISE);

  // Supply choice: forced main, forced backup or comparator driven
  always_comb begin
    if (SUPPLY_SEL == SUP_MAIN) begin
      on_bak_next = 1'b0;
    end else if (SUPPLY_SEL == SUP_BACKUP) begin
      on_bak_next = 1'b1;
    end else begin
      on_bak_next = st_reg[1];
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      on_bak_reg  <= 1'b0;
      PFAIL_THR_O <= '0;
      TRK_ON_O    <= 1'b0;
      TRK_RATE_O  <= '0;
    end else begin
      on_bak_reg  <= on_bak_next;
      PFAIL_THR_O <= POWER_FAIL_THRESHOLD;
      TRK_ON_O    <= TRK_EN && !on_bak_next;
      TRK_RATE_O  <= TRK_RATE;
    end
  end
  assign to_bat_ev   = on_bak_next && !on_bak_reg;
  assign to_main_ev  = !on_bak_next && on_bak_reg;
  assign ON_BACKUP_O = on_bak_reg;

  // Alarm compare one cycle after each seconds step
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      sec_tick_d <= 1'b0;
    end else begin
      sec_tick_d <= sub_wrap;
    end
  end
  assign a1_set = sec_tick_d && alm_hit(ALM1_CFG, sec_v, min_v, hr_v, date_v);
  assign a2_set = sec_tick_d && alm_hit(ALM2_CFG, sec_v, min_v, hr_v, date_v);

  // Count-down timer, loaded when it is switched on
  always_comb begin
    if (TMR_SEL == TMR_128HZ) begin
      tmr_tick = tick;
    end else if (TMR_SEL == TMR_16HZ) begin
      tmr_tick = tick && (sub_v[2:0] == SUB_16_MSK);
    end else if (TMR_SEL == TMR_1HZ) begin
      tmr_tick = sub_wrap;
    end else begin
      tmr_tick = sec_wrap;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      tmr_en_d <= 1'b0;
      tmr_cnt  <= '0;
    end else begin
      tmr_en_d <= TMR_EN;
      if (TMR_EN && !tmr_en_d) begin
        tmr_cnt <= TMR_INIT;
      end else if (TMR_EN && tmr_tick && tmr_cnt != '0) begin
        tmr_cnt <= tmr_cnt - 1'b1;
      end
    end
  end
  assign tmr_zero  = TMR_EN && tmr_en_d && tmr_tick && (tmr_cnt == 8'h01);
  assign TMR_CNT_O = tmr_cnt;

  // Sticky flags: a new event wins over a read in the same cycle
  assign set_v = '{1'b0, din_ev, tmr_zero, a2_set, a1_set};
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      flags_reg <= '0;
      FLAGS_O   <= '0;
    end else begin
      flags_reg <= set_v | (flags_reg & {5{!FLAG_RD}});
      if (FLAG_RD) begin
        FLAGS_O           <= flags_reg | set_v;
        FLAGS_O.on_backup <= on_bak_reg;
      end
    end
  end

  // Interrupt routing and square wave on the shared B pin
  assign a1_irq = flags_reg.a1 && ALM1_IE;
  assign a2_irq = flags_reg.a2 && ALM2_IE;
  assign tm_irq = flags_reg.tmr && TMR_IE;
  assign dn_irq = flags_reg.din && DIN_IE;
  assign sq_sel = (SQUARE_WAVE_OUTPUT_SEL > SQ_SEL_MAX) ? SQ_SEL_MAX : SQUARE_WAVE_OUTPUT_SEL;
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      irqa_reg <= 1'b0;
      irqb_reg <= 1'b0;
      sq_reg   <= 1'b0;
    end else begin
      irqb_reg <= a1_irq && !SQUARE_WAVE_OUTPUT_EN;
      irqa_reg <= a2_irq || tm_irq || dn_irq ||
                  (a1_irq && SQUARE_WAVE_OUTPUT_EN);
      sq_reg   <= sub_v[SQ_SEL_MAX - sq_sel];
    end
  end
  // Open drain: drive low while asserted, release otherwise; B drives both levels while the square wave is on
  assign IRQ_LINE_PRIMARY_O         = 1'b0;
  assign IRQ_LINE_PRIMARY_OE        = irqa_reg;
  assign IRQ_OR_CLOCK_OUTPUT_PIN_O  = SQUARE_WAVE_OUTPUT_EN && sq_reg;
  assign IRQ_OR_CLOCK_OUTPUT_PIN_OE = SQUARE_WAVE_OUTPUT_EN || irqb_reg;

  // Power pass switch: sleep edge opens, timer zero may close
  assign slp_rise = SLEEP_REQUEST_BIT && !slp_d;
  always_comb begin
    ps_next = ps_reg;
    case (ps_reg)
      PS_ON: begin
        if (slp_rise) begin
          ps_next = PS_OFF;
        end
      end
      PS_OFF: begin
        if (tmr_zero && WAKE_TMR_EN) begin
          ps_next = PS_ON;
        end
      end
      default: begin
        ps_next = PS_ON;
      end
    endcase
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      ps_reg <= PS_ON;
      slp_d  <= 1'b0;
    end else begin
      ps_reg <= ps_next;
      slp_d  <= SLEEP_REQUEST_BIT;
    end
  end
  assign PSW_ON_O = (ps_reg == PS_ON);

  // Timestamp records: event flag byte on top, 1/128 s at the bottom
  assign ts_ev = {to_main_ev, to_bat_ev, din_ev} & TS_EV_EN;
  assign ts_go = TS_EN && (ts_ev != '0);
  assign rec   = {5'h00, ts_ev, 1'b0, yr_v, 4'h0, mon_v, 3'h0, date_v,
                  3'h0, hr_v, 2'h0, min_v, 2'h0, sec_v, 1'b0, sub_v};
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN || TS_RST) begin
      ts_cnt <= '0;
      for (int i = 0; i < RAM_SIZE; i++) begin
        mem[i] <= '0;
      end
    end else if (ts_go && ts_cnt != TS_FULL) begin
      ts_cnt <= ts_cnt + 1'b1;
      for (int b = 0; b < TS_BYTES; b++) begin
        mem[{ts_cnt[1:0], 3'(b)}] <= rec[b*8 +: 8];
      end
    end else if (ts_go && TS_OVW) begin
      for (int i = 0; i < RAM_SIZE - TS_BYTES; i++) begin
        mem[i] <= mem[i + TS_BYTES];
      end
      for (int b = 0; b < TS_BYTES; b++) begin
        mem[RAM_SIZE - TS_BYTES + b] <= rec[b*8 +: 8];
      end
    end else if (MEM_WE && !TS_EN) begin
      mem[MEM_ADDR] <= MEM_WDATA;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      MEM_RDATA_O <= '0;
    end else begin
      MEM_RDATA_O <= mem[MEM_ADDR];
    end
  end
  assign TS_CNT_O = ts_cnt;

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  property p_set;
    SET_STB |=> sec_v == $past(SET_TIME.sec) && sub_v == SUB_LO;
  endproperty
  a_set: assert property (p_set) else $error("time not loaded");
  property p_sq;
    SQUARE_WAVE_OUTPUT_EN && $past(SQUARE_WAVE_OUTPUT_EN) |-> IRQ_OR_CLOCK_OUTPUT_PIN_OE &&
      IRQ_OR_CLOCK_OUTPUT_PIN_O == sq_reg;
  endproperty
  a_sq: assert property (p_sq) else $error("no square wave");
  sequence s_a1;
    a1_set ##1 (ALM1_IE && !SQUARE_WAVE_OUTPUT_EN);
  endsequence
  property p_a1;
    s_a1 |=> IRQ_OR_CLOCK_OUTPUT_PIN_OE && !IRQ_OR_CLOCK_OUTPUT_PIN_O;
  endproperty
  a_a1: assert property (p_a1) else $error("alarm one not on B");
  property p_rd;
    FLAG_RD && !a1_set && !a2_set |=> !flags_reg.a1 && !flags_reg.a2
      ##1 !irqb_reg;
  endproperty
  a_rd: assert property (p_rd) else $error("flags not cleared");
  sequence s_a2;
    a2_set ##1 ALM2_IE;
  endsequence
  property p_a2;
    s_a2 |=> IRQ_LINE_PRIMARY_OE;
  endproperty
  a_a2: assert property (p_a2) else $error("alarm two not on A");
  property p_route;
    a1_irq && SQUARE_WAVE_OUTPUT_EN |=> IRQ_LINE_PRIMARY_OE && !irqb_reg;
  endproperty
  a_route: assert property (p_route) else $error("alarm not rerouted");
  property p_tmr;
    tmr_zero |=> tmr_cnt == '0 && flags_reg.tmr;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer zero lost");
  property p_slp;
    slp_rise && ps_reg == PS_ON |=> !PSW_ON_O;
  endproperty
  a_slp: assert property (p_slp) else $error("switch not opened");
  property p_wake;
    tmr_zero && WAKE_TMR_EN && ps_reg == PS_OFF |=> PSW_ON_O;
  endproperty
  a_wake: assert property (p_wake) else $error("switch not closed");
  property p_sup;
    SUPPLY_SEL == SUP_BACKUP |=> ON_BACKUP_O && !TRK_ON_O;
  endproperty
  a_sup: assert property (p_sup) else $error("backup not forced");
  property p_ts_rst;
    TS_RST |=> ts_cnt == '0 && mem[0] == '0;
  endproperty
  a_ts_rst: assert property (p_ts_rst) else $error("records kept");
  property p_first;
    ts_go && !TS_RST && ts_cnt == TS_FULL && !TS_OVW |=> $stable(mem[0]);
  endproperty
  a_first: assert property (p_first) else $error("first four lost");
endmodule

// [bench/rta_host_mon.sv]
// Host-side pin model: pull-ups on both interrupt pins.
// Assumes the block drives a pin only while its enable is high.
`timescale 1ns/10ps
module rta_host_mon (
  input  wire logic a_oe, // A pin pulled low
  input  wire logic b_o,  // B pin level
  input  wire logic b_oe, // B pin driven
  output logic      a_n,  // A wire level
  output logic      b_n   // B wire level
);
  // Released lines float up to the pull-up level
  assign a_n = a_oe ? 1'b0 : 1'b1;
  assign b_n = b_oe ? b_o : 1'b1;
endmodule

// [bench/rta_top_tb.sv]
// Self-checking bench for the real-time clock core.
// Assumes TICK_DIV of 4, so one second is 512 clocks.
`timescale 1ns/10ps
module rta_top_tb;
  import rta_pkg::*;
  logic CLK_SYS, RESETN, SET_STB, FMT_12H, SQUARE_WAVE_OUTPUT_EN, ALM1_IE, ALM2_IE;
  logic TMR_EN, TMR_IE, FLAG_RD, DIN_PIN, DIN_RISE, DIN_IE, WAKE_TMR_EN;
  logic SLEEP_REQUEST_BIT, VCC_LOW_PIN, TRK_EN, TS_EN, TS_OVW, TS_RST;
  logic MEM_WE, PM_O, PSW_ON_O, ON_BACKUP_O, TRK_ON_O, a_n, b_n;
  logic IRQ_LINE_PRIMARY_O, IRQ_LINE_PRIMARY_OE;
  logic IRQ_OR_CLOCK_OUTPUT_PIN_O, IRQ_OR_CLOCK_OUTPUT_PIN_OE;
  logic [1:0] TMR_SEL, SUPPLY_SEL, TRK_RATE, TRK_RATE_O;
  logic [2:0] SQUARE_WAVE_OUTPUT_SEL, POWER_FAIL_THRESHOLD, PFAIL_THR_O, TS_EV_EN;
  logic [2:0] TS_CNT_O;
  logic [4:0] MEM_ADDR;
  logic [6:0] SUBSEC_O;
  logic [7:0] TMR_INIT, TMR_CNT_O, MEM_WDATA, MEM_RDATA_O;
  rta_time_t  SET_TIME, TIME_O;
  rta_alarm_t ALM1_CFG, ALM2_CFG;
  rta_flags_t FLAGS_O;
  int         bad_count, checks, n;
  rta_top #(.TICK_DIV(4)) rta_top_i (.CLK_SYS, .RESETN, .SET_STB,
    .SET_TIME, .FMT_12H, .TIME_O, .PM_O, .SUBSEC_O, .SQUARE_WAVE_OUTPUT_EN,
    .SQUARE_WAVE_OUTPUT_SEL, .ALM1_CFG, .ALM1_IE, .ALM2_CFG, .ALM2_IE, .TMR_EN,
    .TMR_IE, .TMR_SEL, .TMR_INIT, .TMR_CNT_O, .FLAG_RD, .FLAGS_O,
    .DIN_PIN, .DIN_RISE, .DIN_IE, .SLEEP_REQUEST_BIT, .WAKE_TMR_EN,
    .PSW_ON_O, .SUPPLY_SEL, .POWER_FAIL_THRESHOLD, .PFAIL_THR_O,
    .VCC_LOW_PIN, .ON_BACKUP_O, .TRK_EN, .TRK_RATE, .TRK_ON_O,
    .TRK_RATE_O, .TS_EN, .TS_EV_EN, .TS_OVW, .TS_RST, .TS_CNT_O,
    .MEM_WE, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA_O, .IRQ_LINE_PRIMARY_O,
    .IRQ_LINE_PRIMARY_OE, .IRQ_OR_CLOCK_OUTPUT_PIN_O,
    .IRQ_OR_CLOCK_OUTPUT_PIN_OE);
  rta_host_mon rta_host_mon_i (.a_oe(IRQ_LINE_PRIMARY_OE),
    .b_o(IRQ_OR_CLOCK_OUTPUT_PIN_O), .b_oe(IRQ_OR_CLOCK_OUTPUT_PIN_OE),
    .a_n(a_n), .b_n(b_n));
  // Clock source
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge CLK_SYS);
  endtask
  task automatic chk(input string nm, input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One-cycle flag read pulse, flags land one edge later
  task automatic rd_flags();
    FLAG_RD = 1'b1;
    cyc(1);
    FLAG_RD = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Time load, then second alarm on A, then read-and-clear
  task automatic t_alarm();
    SET_TIME = '{7'h00, 4'h1, 5'h01, 3'h1, 5'h00, 6'h00, 6'h0a};
    ALM2_CFG = '{4'he, 5'h00, 5'h00, 6'h00, 6'h0b};
    ALM1_CFG = ALM2_CFG;
    rd_flags();
    cyc(1);
    rd_flags();
    {ALM1_IE, ALM2_IE, FMT_12H} = 3'h7;
    SET_STB = 1'b1;
    cyc(1);
    SET_STB = 1'b0;
    cyc(2);
    chk("sec0", TIME_O.sec, 8'h0a);
    chk("hr12", TIME_O.hour, 8'h0c);
    chk("sub0", SUBSEC_O, 8'h00);
    chk("a_idle", a_n, 1'b1);
    chk("b_idle", b_n, 1'b1);
    cyc(520);
    chk("sec1", TIME_O.sec, 8'h0b);
    chk("sub2", SUBSEC_O, 8'h02);
    chk("a_low", a_n, 1'b0);
    chk("a_lvl", IRQ_LINE_PRIMARY_O, 1'b0);
    chk("b_low", b_n, 1'b0);
    rd_flags();
    chk("a2", FLAGS_O.a2, 1'b1);
    chk("a1", FLAGS_O.a1, 1'b1);
    cyc(2);
    chk("a_rel", a_n, 1'b1);
    chk("b_rel", b_n, 1'b1);
    {ALM1_IE, ALM2_IE} = 2'h0;
    $display("alarm test done");
  endtask
  // Sleep opens switch; timer zero closes it and pulls A low
  task automatic t_timer();
    SLEEP_REQUEST_BIT = 1'b1;
    cyc(2);
    chk("psw_off", PSW_ON_O, 1'b0);
    {WAKE_TMR_EN, TMR_IE, TMR_EN} = 3'h7;
    TMR_INIT = 8'h03;
    cyc(3);
    chk("tload", TMR_CNT_O, 8'h03);
    n = 0;
    while (TMR_CNT_O !== 8'h00 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("tcnt", TMR_CNT_O, 8'h00);
    cyc(2);
    chk("psw_on", PSW_ON_O, 1'b1);
    chk("a_tmr", a_n, 1'b0);
    rd_flags();
    chk("tflag", FLAGS_O.tmr, 1'b1);
    $display("timer test done");
  endtask
  // Square wave on B, supply switch with log, RAM and clear
  task automatic t_misc();
    SQUARE_WAVE_OUTPUT_EN = 1'b1;
    SQUARE_WAVE_OUTPUT_SEL = 3'h6;
    cyc(2);
    n = 0;
    repeat (40) begin
      cyc(1);
      if (b_n !== IRQ_OR_CLOCK_OUTPUT_PIN_O) n = 99;
      else if (b_n !== a_n) n++;
    end
    chk("b_oe", IRQ_OR_CLOCK_OUTPUT_PIN_OE, 1'b1);
    chk("b_run", n[7:0], 8'h14);
    {TS_EN, TS_EV_EN, TRK_EN, SUPPLY_SEL} = {1'b1, 3'h2, 1'b1, SUP_BACKUP};
    {POWER_FAIL_THRESHOLD, TRK_RATE} = {3'h5, 2'h3};
    cyc(4);
    chk("bkup", ON_BACKUP_O, 1'b1);
    chk("pft", PFAIL_THR_O, 8'h05);
    chk("trk", TRK_ON_O, 1'b0);
    chk("trate", TRK_RATE_O, 8'h03);
    chk("ts1", TS_CNT_O, 8'h01);
    rd_flags();
    chk("fbk", FLAGS_O.on_backup, 1'b1);
    {DIN_RISE, DIN_IE, DIN_PIN, TS_EV_EN} = {3'h7, 3'h3};
    cyc(6);
    chk("din_a", a_n, 1'b0);
    chk("ts2", TS_CNT_O, 8'h02);
    rd_flags();
    chk("fdin", FLAGS_O.din, 1'b1);
    {TS_EN, MEM_WE, MEM_ADDR, MEM_WDATA} = {2'h1, 5'h05, 8'ha5};
    cyc(1);
    MEM_WE = 1'b0;
    cyc(2);
    chk("ram", MEM_RDATA_O, 8'ha5);
    TS_RST = 1'b1;
    cyc(1);
    TS_RST = 1'b0;
    cyc(2);
    chk("rclr", MEM_RDATA_O, 8'h00);
    chk("tsclr", TS_CNT_O, 8'h00);
    $display("misc test done");
  endtask
  // Watchdog sized well beyond the three tests
  initial begin
    repeat (5000) @(posedge CLK_SYS);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {RESETN, SET_STB, FMT_12H, SQUARE_WAVE_OUTPUT_EN, ALM1_IE, ALM2_IE, TMR_EN} = '0;
    {TMR_IE, FLAG_RD, DIN_PIN, DIN_RISE, DIN_IE, WAKE_TMR_EN} = '0;
    {SLEEP_REQUEST_BIT, VCC_LOW_PIN, TRK_EN, TS_EN, TS_OVW, TS_RST} = '0;
    {MEM_WE, TMR_SEL, SUPPLY_SEL, TRK_RATE, SQUARE_WAVE_OUTPUT_SEL} = '0;
    {POWER_FAIL_THRESHOLD, TS_EV_EN, MEM_ADDR, TMR_INIT, MEM_WDATA} = '0;
    {SET_TIME, ALM1_CFG, ALM2_CFG} = '0;
    bad_count = 0;
    checks = 0;
    cyc(20);
    RESETN = 1'b1;
    chk("rst_psw", PSW_ON_O, 1'b1);
    t_alarm();
    t_timer();
    t_misc();
    tally_and_finish();
  end
endmodule
